// >>> src/dauc_defs.vh
// constants for the converter update control: register map, field
// positions, reset values and the conversion time.
// assumes a 32-bit axi4-lite bus and a 20 MHz system clock.
`ifndef DAUC_DEFS_VH
`define DAUC_DEFS_VH

// ==========================================================
// register byte addresses
`define DAUC_ADDR_CONFIG 4'h0
`define DAUC_ADDR_HIGH 4'h4
`define DAUC_ADDR_LOW 4'h8
`define DAUC_ADDR_STATUS 4'hC
`define DAUC_ADDR_W 4

// ==========================================================
// converter_config fields
`define DAUC_CFG_EN 0
`define DAUC_CFG_OE 1
`define DAUC_CFG_LA 2
`define DAUC_CFG_TS_LO 4
`define DAUC_CFG_TS_HI 6
`define DAUC_CFG_ATE 7
`define DAUC_CFG_MASK 8'hF7
`define DAUC_CFG_RESET 8'h00
`define DAUC_VAL_RESET 8'h00

// value byte masks per alignment
`define DAUC_HIGH_MASK_RIGHT 8'h03
`define DAUC_LOW_MASK_LEFT 8'hC0
`define DAUC_FULL_MASK 8'hFF

// ==========================================================
// status register fields
`define DAUC_ST_BUSY 16
`define DAUC_ST_PEND 17

// ==========================================================
// conversion (settling) time and its cycle count
// 1000 ns of settling at a 50 ns clock, sized to the counter width
`define DAUC_CONV_CYC 5'h14
`define DAUC_CNT_W 5

// ==========================================================
// bus responses
`define DAUC_RESP_OKAY 2'h0
`define DAUC_RESP_SLVERR 2'h2
`define DAUC_ZERO32 32'h00000000

`endif

// >>> src/dauc_top.v
// converter update control: axi4-lite registers, shadow code,
// alignment and trigger-driven loading for a 10-bit converter.
// assumes synchronous event flags and a single-clock system.
// the analog core and its reference selection live outside this block.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dauc_defs.vh"

module dauc_top (
  input wire sys_clk_i,
  input wire rst_i,
  // axi4-lite write address
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [`DAUC_ADDR_W-1:0] s_axi_awaddr_i,
  // axi4-lite write data
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  output reg [1:0] s_axi_bresp_o,
  // axi4-lite read address
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  input wire [`DAUC_ADDR_W-1:0] s_axi_araddr_i,
  // axi4-lite read data
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  // event flags from comparators, interrupt and timers
  input wire [7:0] trig_flags_i,
  // towards the analog core
  output reg [9:0] dac_code_o,
  output reg dac_load_o,
  output reg converter_enable_o,
  output reg analog_output_pin_en_o
);

  // ==========================================================
  // declarations
  // the counter is just wide enough for the settling count; a longer
  // settling time needs DAUC_CNT_W raised with it
  localparam [`DAUC_CNT_W-1:0] CONV_CYC = `DAUC_CONV_CYC; // settling cycles
  localparam [`DAUC_CNT_W-1:0] CNT_ZERO = 5'h00; // idle count
  localparam [`DAUC_CNT_W-1:0] CNT_ONE = 5'h01; // count step

  reg [7:0] converter_config; // software configuration
  reg [7:0] value_high_byte; // stored high value byte
  reg [7:0] value_low_byte; // stored low value byte
  reg low_pending; // low written, high not yet
  reg [`DAUC_CNT_W-1:0] conv_cnt; // cycles left in conversion
  reg aw_have; // write address held
  reg w_have; // write data held
  reg [`DAUC_ADDR_W-1:0] wr_addr; // held write address
  reg [7:0] wr_byte; // held write byte lane 0
  reg wr_lane; // lane 0 strobe held
  reg [31:0] next_rdata; // decoded read word
  reg next_rok; // read address mapped
  reg [7:0] wr_high; // masked high byte for a write
  reg [7:0] wr_low; // masked low byte for a write
  wire trig_rise; // selected flag rose
  wire auto_mode; // auto-trigger selected
  wire left_adj; // left alignment selected
  wire conv_busy; // conversion in progress
  wire wr_go; // both write halves present
  wire wr_map; // write address mapped

  assign auto_mode = converter_config[`DAUC_CFG_ATE];
  assign left_adj = converter_config[`DAUC_CFG_LA];
  assign conv_busy = (conv_cnt != CNT_ZERO);
  assign wr_go = aw_have & w_have & ~s_axi_bvalid_o;
  assign wr_map = (wr_addr == `DAUC_ADDR_CONFIG) || (wr_addr == `DAUC_ADDR_HIGH) ||
                  (wr_addr == `DAUC_ADDR_LOW) || (wr_addr == `DAUC_ADDR_STATUS);

  // ==========================================================
  // code assembly from the value bytes
  // right-adjusted layout
  // left-adjusted layout
  // only a rearrangement of bits; the shadow itself is dac_code_o
  function [9:0] dauc_code;
    input [7:0] hi;
    input [7:0] lo;
    input left;
    begin
      if (left) begin
        dauc_code = {hi, lo[7:6]};
      end else begin
        dauc_code = {hi[1:0], lo};
      end
    end
  endfunction

  // ==========================================================
  // trigger edge detection
  // registered flag edge used
  // the edge finder adds one register stage, so a load follows a
  // flag rise by two clocks
  dauc_trig_edge i_dauc_trig_edge (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flags_i(trig_flags_i),
    .sel_i(converter_config[`DAUC_CFG_TS_HI:`DAUC_CFG_TS_LO]),
    .rise_o(trig_rise)
  );

  // ==========================================================
  // masking of value bytes on write
  // reserved positions depend on the alignment in force at the write
  // alignment select
  always @* begin
    if (left_adj) begin
      wr_high = wr_byte & `DAUC_FULL_MASK;
      wr_low = wr_byte & `DAUC_LOW_MASK_LEFT;
    end else begin
      wr_high = wr_byte & `DAUC_HIGH_MASK_RIGHT;
      wr_low = wr_byte & `DAUC_FULL_MASK;
    end
  end

  // ==========================================================
  // axi write channels and register updates
  // address and data are taken in either order; the response follows
  // both and new requests wait until the response is accepted
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `DAUC_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wr_addr <= `DAUC_ADDR_CONFIG;
      wr_byte <= `DAUC_VAL_RESET;
      wr_lane <= 1'b0;
      converter_config <= `DAUC_CFG_RESET;
      value_high_byte <= `DAUC_VAL_RESET;
      value_low_byte <= `DAUC_VAL_RESET;
      low_pending <= 1'b0;
      dac_code_o <= 10'h000;
      dac_load_o <= 1'b0;
      conv_cnt <= CNT_ZERO;
      converter_enable_o <= 1'b0;
      analog_output_pin_en_o <= 1'b0;
    end else begin
      dac_load_o <= 1'b0;
      // conversion time runs down after every load
      if (conv_busy) begin
        conv_cnt <= conv_cnt - CNT_ONE;
      end
      // capture address
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have <= 1'b1;
        wr_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      // capture data, lane 0 only carries register bits
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have <= 1'b1;
        wr_byte <= s_axi_wdata_i[7:0];
        wr_lane <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      // the trigger path reads the stored bytes, never the bus, so a
      // write landing in the same cycle is picked up by the next edge
      // trigger loads shadow
      if (auto_mode && trig_rise && !low_pending && !conv_busy) begin
        dac_code_o <= dauc_code(value_high_byte, value_low_byte, left_adj);
        dac_load_o <= 1'b1;
        conv_cnt <= CONV_CYC;
      end
      // perform the write once both halves are held
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? `DAUC_RESP_OKAY : `DAUC_RESP_SLVERR;
        if (wr_lane) begin
          case (wr_addr)
            `DAUC_ADDR_CONFIG: begin
              converter_config <= wr_byte & `DAUC_CFG_MASK;
              converter_enable_o <= wr_byte[`DAUC_CFG_EN];
              analog_output_pin_en_o <= wr_byte[`DAUC_CFG_OE];
            end
            `DAUC_ADDR_LOW: begin
              value_low_byte <= wr_low;
              low_pending <= 1'b1;
            end
            `DAUC_ADDR_HIGH: begin
              value_high_byte <= wr_high;
              low_pending <= 1'b0;
              // a normal-mode load restarts the settling time even when
              // busy; software owns the pacing in that mode
              // normal mode load
              if (!auto_mode) begin
                dac_code_o <= dauc_code(wr_high, value_low_byte, left_adj);
                dac_load_o <= 1'b1;
                conv_cnt <= CONV_CYC;
              end
            end
            default: begin
              // status and unmapped words take no write
            end
          endcase
        end
      end
      // response accepted, reopen both channels
      // ready stays low until the response is taken, which keeps one
      // write outstanding and makes a second write wait
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read decode
  // the shadow itself has no address; status only mirrors it
  always @* begin
    next_rdata = `DAUC_ZERO32;
    next_rok = 1'b1;
    case (s_axi_araddr_i)
      `DAUC_ADDR_CONFIG: begin
        next_rdata[7:0] = converter_config;
      end
      `DAUC_ADDR_HIGH: begin
        next_rdata[7:0] = value_high_byte &
          (left_adj ? `DAUC_FULL_MASK : `DAUC_HIGH_MASK_RIGHT);
      end
      `DAUC_ADDR_LOW: begin
        next_rdata[7:0] = value_low_byte &
          (left_adj ? `DAUC_LOW_MASK_LEFT : `DAUC_FULL_MASK);
      end
      `DAUC_ADDR_STATUS: begin
        next_rdata[9:0] = dac_code_o;
        next_rdata[`DAUC_ST_BUSY] = conv_busy;
        next_rdata[`DAUC_ST_PEND] = low_pending;
      end
      default: begin
        // unmapped words answer with an error and zero data
        next_rok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // axi read channels
  // one read at a time: address refused while data is outstanding
  // arready and rvalid are never high together, so a new address
  // can not overwrite data the master has not yet taken
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `DAUC_ZERO32;
      s_axi_rresp_o <= `DAUC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= next_rdata;
        s_axi_rresp_o <= next_rok ? `DAUC_RESP_OKAY : `DAUC_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> src/dauc_trig_edge.v
// rising-edge finder for the eight on-chip event flags.
// assumes the flags are synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module dauc_trig_edge (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] flags_i,
  input wire [2:0] sel_i,
  output reg rise_o
);

  // ==========================================================
  // per-flag history
  // every flag keeps its own history, so a change of the select
  // field never fakes an edge from an unrelated flag
  wire [7:0] rise; // one-cycle rise of each flag
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : flag_hist
      reg prev; // flag value one clock ago
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          prev <= 1'b0;
        end else begin
          prev <= flags_i[g];
        end
      end
      assign rise[g] = flags_i[g] & ~prev;
    end
  endgenerate

  // ==========================================================
  // selected edge, registered
  // pick chosen source
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_o <= 1'b0;
    end else begin
      rise_o <= rise[sel_i];
    end
  end

endmodule

`default_nettype wire

// >>> tb/dauc_event_model.sv
// event flag model: eight flags set on request, held until cleared.
// assumes requests are synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
// ==========================
// event flags
module dauc_event_model (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] set_i,
  input wire clear_i,
  output logic [7:0] flags_o
);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= 8'h00;
    end else begin
      flags_o <= clear_i ? 8'h00 : flags_o | set_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dauc_top_monitor.sv
// checker for the converter update control ports.
// assumes binding to dauc_top; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
`include "dauc_defs.vh"
// ==========================
// checker
module dauc_top_monitor (
  input wire sys_clk_i,
  input wire rst_i,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [7:0] trig_flags_i,
  input wire [9:0] dac_code_o,
  input wire dac_load_o,
  input wire converter_enable_o,
  input wire analog_output_pin_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] flg_q; // flags a cycle ago
  logic rise_q; // some flag rose
  logic [4:0] busy; // conversion cycles left
  // mirror of edge finder and timer; any flag counts, so it is loose on select
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flg_q <= 8'h00;
      rise_q <= 1'b0;
      busy <= 5'h00;
    end else begin
      flg_q <= trig_flags_i;
      rise_q <= |(trig_flags_i & ~flg_q);
      busy <= dac_load_o ? `DAUC_CONV_CYC : busy - {4'h0, busy != 5'h00};
    end
  end
  property p_code; !$stable(dac_code_o) |-> dac_load_o; endproperty
  a_code: assert property (p_code) else $error("code moved without load");
  property p_edge; dac_load_o && !$rose(s_axi_bvalid_o) |-> $past(rise_q); endproperty
  a_edge: assert property (p_edge) else $error("load without edge");
  property p_busy; dac_load_o && !$rose(s_axi_bvalid_o) |-> busy == 5'h00; endproperty
  a_busy: assert property (p_busy) else $error("trigger load while busy");
  property p_cfg;
    !$stable({converter_enable_o, analog_output_pin_en_o}) |-> $rose(s_axi_bvalid_o);
  endproperty
  a_cfg: assert property (p_cfg) else $error("enable moved without write");
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rvalid_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_arblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  c_trig: cover property (dac_load_o && !$rose(s_axi_bvalid_o));
  c_bwait: cover property (s_axi_bvalid_o && !s_axi_bready_i);
  c_rwait: cover property (s_axi_rvalid_o && !s_axi_rready_i);
endmodule
bind dauc_top dauc_top_monitor i_dauc_top_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .trig_flags_i(trig_flags_i), .dac_code_o(dac_code_o),
  .dac_load_o(dac_load_o), .converter_enable_o(converter_enable_o),
  .analog_output_pin_en_o(analog_output_pin_en_o));
`default_nettype wire

// >>> tb/test_dauc_top.sv
// bench for the converter update control: bus master, flag model,
// queued notes checked by a watcher. assumes dauc_defs.vh on path.
`timescale 1ns/1ps
`default_nettype none
`include "dauc_defs.vh"
// ==========================
// bench top
module test_dauc_top;
  localparam logic [3:0] CFG = `DAUC_ADDR_CONFIG, HI = `DAUC_ADDR_HIGH, LO = `DAUC_ADDR_LOW;
  localparam logic [1:0] OK = `DAUC_RESP_OKAY, ERR = `DAUC_RESP_SLVERR;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic bready = 1'b0, rready = 1'b0, clr = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h00000000;
  logic [7:0] fset = 8'h00, cfg = 8'h00, lo, hi;
  logic [9:0] code;
  wire awr, wrdy, bv, arr, rv, load, en, oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [9:0] dcode;
  wire [7:0] flags;
  logic [3:0] bq[$]; // response and enables
  logic [33:0] rq[$]; // response and read data
  logic [9:0] cq[$]; // codes to be loaded
  int mismatches = 0, total_checks = 0;
  dauc_top i_dauc_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .trig_flags_i(flags), .dac_code_o(dcode),
    .dac_load_o(load), .converter_enable_o(en), .analog_output_pin_en_o(oe));
  dauc_event_model i_dauc_event_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .set_i(fset),
    .clear_i(clr), .flags_o(flags));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  // write; a slow ready makes the response stand
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic slow;
    slow = 1'($urandom);
    if (a == CFG && r == OK && wstrb[0]) cfg = d & `DAUC_CFG_MASK;
    bq.push_back({r, cfg[0], cfg[1]});
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= !slow;
    do @(posedge sys_clk_i); while (!(awr && wrdy));
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge sys_clk_i); while (!bv);
    if (slow) begin
      bready <= 1'b1;
      @(posedge sys_clk_i);
    end
    bready <= 1'b0;
  endtask
  // read, same slow ready habit
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic slow;
    slow = 1'($urandom);
    rq.push_back({r, d});
    @(posedge sys_clk_i);
    araddr <= a;
    arv <= 1'b1;
    rready <= !slow;
    do @(posedge sys_clk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge sys_clk_i); while (!rv);
    if (slow) begin
      rready <= 1'b1;
      @(posedge sys_clk_i);
    end
    rready <= 1'b0;
  endtask
  // request flags, held until cleared, or clear all when s is zero, for one cycle, then wait n+1 cycles
  task automatic ev(input logic [7:0] s, input int n);
    fset <= s;
    clr <= (s == 8'h00);
    @(posedge sys_clk_i);
    fset <= 8'h00;
    clr <= 1'b0;
    repeat (n + 1) @(posedge sys_clk_i);
  endtask
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watcher: each result against the oldest note
  always @(posedge sys_clk_i) begin
    if (bv && bready) begin
      total_checks++;
      if (bq.size() == 0 || {bresp, en, oe} !== bq.pop_front()) begin
        mismatches++;
        $display("unexpected %0t write response or enables", $time);
      end
    end
    if (rv && rready) begin
      total_checks++;
      if (rq.size() == 0 || {rresp, rdata} !== rq.pop_front()) begin
        mismatches++;
        $display("unexpected %0t read data", $time);
      end
    end
    if (load) begin
      total_checks++;
      if (cq.size() == 0 || dcode !== cq.pop_front()) begin
        mismatches++;
        $display("unexpected %0t code load", $time);
      end
    end
  end
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    mismatches++;
    $display("unexpected %0t timeout", $time);
    final_report();
  end
  initial begin
    lo = 8'($urandom(32'h966f2542));
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(CFG, 32'h0, OK);
    rd(LO, 32'h0, OK);
    wr(4'h2, 8'hFF, ERR);
    rd(4'h2, 32'h0, ERR);
    wr(CFG, 8'hFF, OK);
    rd(CFG, 32'hF7, OK);
    wr(CFG, 8'h01, OK);
    wstrb <= 4'hE;
    @(posedge sys_clk_i);
    wr(CFG, 8'h00, OK);
    wstrb <= 4'hF;
    rd(CFG, 32'h01, OK);
    repeat (4) begin
      code = 10'($urandom);
      hi = 8'($urandom);
      hi[1:0] = code[9:8];
      wr(LO, code[7:0], OK);
      cq.push_back(code);
      wr(HI, hi, OK);
      rd(HI, {24'h0, hi & 8'h03}, OK);
    end
    lo = 8'($urandom);
    wr(LO, lo, OK);
    wr(CFG, 8'h05, OK);
    rd(LO, {24'h0, lo & 8'hC0}, OK);
    repeat (2) begin
      hi = 8'($urandom);
      cq.push_back({hi, lo[7:6]});
      wr(HI, hi, OK);
    end
    for (int s = 0; s < 8; s++) begin
      code = 10'($urandom);
      wr(CFG, {1'b1, 3'(s), 4'h1}, OK);
      wr(LO, code[7:0], OK);
      wr(HI, {6'h00, code[9:8]}, OK);
      ev(8'(1 << ((s + 1) % 8)), 25);
      ev(8'h00, 1);
      cq.push_back(code);
      ev(8'(1 << s), 6);
      ev(8'h00, 1);
      ev(8'(1 << s), 30);
      ev(8'h00, 1);
    end
    lo = 8'($urandom);
    wr(LO, lo, OK);
    ev(8'h80, 25);
    ev(8'h00, 1);
    hi = 8'($urandom);
    wr(HI, hi, OK);
    cq.push_back({hi[1:0], lo});
    ev(8'h80, 25);
    ev(8'h00, 1);
    cq.push_back({hi[1:0], lo});
    ev(8'h80, 25);
    rd(`DAUC_ADDR_STATUS, {22'h0, hi[1:0], lo}, OK);
    if (cq.size() != 0) begin
      mismatches++;
      $display("unexpected %0t missing code load", $time);
    end
    final_report();
  end
endmodule
`default_nettype wire
